// ---- core/wdc_top.sv ----
/*
 Watchdog down counter with its APB register slave, prescaler and
 interrupt logic.
 Assumes one 100 MHz clock, an asynchronous external count clock pin and
 a debug halt level from the processor on the same clock.
*/

// How it works
// - A 32-bit counter counts down and on reaching zero raises an interrupt or a reset.
// - The current count register reads the live value of the down counter.
// - After reset the control register selects enabled counting with reset on underflow.
// - The counter only moves while the counter enable bit 4 is set.
// - When bit 4 is set by a write the count starts from the reload register; after reset it starts from COUNT_RST.
// - With reset enable bit 6 set, reaching zero asserts the watchdog reset.
// - In interrupt mode the counter reloads itself after reaching zero.
// - That automatic reload only happens while the interrupt enable bit is set.
// - A written reload value reaches the counter within five counter clocks.
// - Interrupt and readable count lag the counter by at most two bus clocks.
// - Clock select bit 3 picks the bus clock at 0 and the external clock at 1.
// - The 3-bit prescaler divides by 1, 4, 8, 16, 32, 64, 128 or 256.
// - Time-out is reload value times the counter clock period plus sync latency.
module wdc_top (
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic        ext_clk_i,
   input  wire logic        debug_halt_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   output logic             wdt_reset_o
);

   // Register state
   wdc_pkg::wdc_ctrl_t ctrl_ff;
   logic [31:0]        reload_ff;
   logic [31:0]        count_ff;
   logic               pending_ff;
   logic               upd_ff;
   logic               en_prev_ff;
   logic               wdt_reset_ff;

   // Bus slave state
   logic               pready_ff;
   logic [31:0]        prdata_ff;
   logic               pslverr_ff;

   // Combinational terms
   logic               setup;
   logic               access;
   logic               wr;
   logic [31:0]        rdata;
   logic               err;
   logic               freeze;
   logic               run;
   logic               tick;
   logic               start;
   logic               step;
   logic               take;
   logic               uf;
   logic [wdc_pkg::IRQ_NUM-1:0] irq_set;
   logic [wdc_pkg::IRQ_NUM-1:0] status;
   logic [wdc_pkg::IRQ_NUM-1:0] ien;

   // APB phases: one setup, one access, no wait states
   assign setup  = psel_i & ~penable_i;
   assign access = psel_i & penable_i & pready_ff;
   assign wr     = access & pwrite_i;

   // Debug freeze when the run-in-debug bit is clear
   assign freeze = debug_halt_i & ~ctrl_ff.debug_halt_control;
   assign run    = ctrl_ff.counter_enable & ~freeze;

   wdc_prescaler u_prescaler (
      .clock_i   (clock_i),
      .rst_b_i   (rst_b_i),
      .ext_clk_i (ext_clk_i),
      .run_i     (run),
      .src_sel_i (ctrl_ff.clock_source_select),
      .code_i    (ctrl_ff.prescale_select),
      .tick_o    (tick)
   );

   // Counter events
   assign start = ctrl_ff.counter_enable & ~en_prev_ff;
   assign step  = tick & run & ~start;
   assign take  = step & pending_ff;
   // Zero is reached on the step out of one
   assign uf    = step & ~pending_ff & (count_ff == 32'h0000_0001);

   // Control register
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         ctrl_ff <= wdc_pkg::wdc_ctrl_t'(wdc_pkg::CTRL_RST);
      end else if (wr && paddr_i == wdc_pkg::ADDR_CTRL) begin
         ctrl_ff <= wdc_pkg::wdc_ctrl_t'(pwdata_i[15:0] & wdc_pkg::CTRL_WR_MASK);
      end
   end

   // Reload register
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         reload_ff <= wdc_pkg::RELOAD_RST;
      end else if (wr && paddr_i == wdc_pkg::ADDR_RELOAD) begin
         reload_ff <= pwdata_i;
      end
   end

   // Enable edge detector
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         en_prev_ff <= 1'b1;
      end else begin
         en_prev_ff <= ctrl_ff.counter_enable;
      end
   end

   // A reload write retargets the count only while counting is enabled
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         pending_ff <= 1'b0;
      end else if (wr && paddr_i == wdc_pkg::ADDR_RELOAD) begin
         pending_ff <= ctrl_ff.counter_enable;
      end else if (take || start) begin
         pending_ff <= 1'b0;
      end
   end

   // Update flag: cleared by a new reload write, set when it is taken
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         upd_ff <= 1'b0;
      end else if (wr && paddr_i == wdc_pkg::ADDR_RELOAD) begin
         upd_ff <= 1'b0;
      end else if (take) begin
         upd_ff <= 1'b1;
      end
   end

   // Down counter
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         count_ff <= wdc_pkg::COUNT_RST;
      end else if (start) begin
         count_ff <= reload_ff;
      end else if (take) begin
         count_ff <= reload_ff;
      end else if (step) begin
         if (count_ff != 32'h0000_0000) begin
            count_ff <= count_ff - 32'h0000_0001;
         end else if (ctrl_ff.underflow_irq_enable) begin
            // Restarts the count from the reload value so the next interrupt follows one period later
            count_ff <= reload_ff;
         end
      end
   end

   // Watchdog reset holds until the system reset clears it
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         wdt_reset_ff <= 1'b0;
      end else if (uf && ctrl_ff.underflow_reset_enable) begin
         wdt_reset_ff <= 1'b1;
      end
   end

   // Interrupt sources
   always_comb begin
      irq_set = '0;
      irq_set[wdc_pkg::IRQ_UNDERFLOW] = uf & ctrl_ff.underflow_irq_enable;
      irq_set[wdc_pkg::IRQ_LOADED]    = take;
   end

   wdc_irq #(
      .N (wdc_pkg::IRQ_NUM)
   ) u_irq (
      .clock_i  (clock_i),
      .rst_b_i  (rst_b_i),
      .set_i    (irq_set),
      .clr_wr_i (wr && paddr_i == wdc_pkg::ADDR_CLR),
      .ien_wr_i (wr && paddr_i == wdc_pkg::ADDR_IEN),
      .wdata_i  (pwdata_i[wdc_pkg::IRQ_NUM-1:0]),
      .status_o (status),
      .ien_o    (ien),
      .irq_o    (irq_o)
   );

   // Read data and error decode
   always_comb begin
      rdata = 32'h0000_0000;
      err   = 1'b0;
      unique case (paddr_i)
         wdc_pkg::ADDR_RELOAD: begin
            rdata = reload_ff;
         end
         wdc_pkg::ADDR_COUNT: begin
            rdata = count_ff;
            err   = pwrite_i;
         end
         wdc_pkg::ADDR_CTRL: begin
            rdata[15:0] = ctrl_ff;
            rdata[8]    = upd_ff;
         end
         wdc_pkg::ADDR_STAT: begin
            rdata[wdc_pkg::IRQ_NUM-1:0] = status;
            err = pwrite_i;
         end
         wdc_pkg::ADDR_CLR: begin
            rdata = 32'h0000_0000;
         end
         wdc_pkg::ADDR_IEN: begin
            rdata[wdc_pkg::IRQ_NUM-1:0] = ien;
         end
         default: begin
            err = 1'b1;
         end
      endcase
   end

   // Answer is prepared in setup and shown in access
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup & err;
         if (setup) begin
            prdata_ff <= pwrite_i ? 32'h0000_0000 : rdata;
         end
      end
   end

   assign prdata_o    = prdata_ff;
   assign pready_o    = pready_ff;
   assign pslverr_o   = pslverr_ff;
   assign wdt_reset_o = wdt_reset_ff;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   localparam int LAG_MIN = 1;
   localparam int LAG_MAX = 2;

   zero_reach_a: assert property (
      uf |=> count_ff == 32'h0000_0000)
      else $error("Counter did not reach zero");
   count_read_a: assert property (
      setup && !pwrite_i && paddr_i == wdc_pkg::ADDR_COUNT
      |=> prdata_o == $past(count_ff))
      else $error("Count read mismatch");
   reset_default_a: assert property (@(posedge clock_i) disable iff (1'b0)
      !rst_b_i |=> ctrl_ff == wdc_pkg::wdc_ctrl_t'(wdc_pkg::CTRL_RST) && !wdt_reset_o)
      else $error("Control not at default after reset");
   hold_disabled_a: assert property (
      !ctrl_ff.counter_enable |=> $stable(count_ff))
      else $error("Counter moved while disabled");
   start_load_a: assert property (
      start |=> count_ff == $past(reload_ff))
      else $error("Enable did not load the reload value");
   reset_out_a: assert property (
      uf && ctrl_ff.underflow_reset_enable |=> wdt_reset_o [*3])
      else $error("Watchdog reset not asserted");
   auto_reload_a: assert property (
      step && !pending_ff && count_ff == 32'h0000_0000 && ctrl_ff.underflow_irq_enable
      |=> count_ff == $past(reload_ff))
      else $error("No reload after underflow");
   no_reload_a: assert property (
      step && !pending_ff && count_ff == 32'h0000_0000 && !ctrl_ff.underflow_irq_enable
      |=> count_ff == 32'h0000_0000)
      else $error("Reload without interrupt mode");
   load_take_a: assert property (
      take |=> count_ff == $past(reload_ff) && !pending_ff && ctrl_ff.counter_enable)
      else $error("Reload value not taken");
   irq_lag_a: assert property (
      uf && ctrl_ff.underflow_irq_enable && ien[wdc_pkg::IRQ_UNDERFLOW]
      |-> ##[LAG_MIN:LAG_MAX] irq_o)
      else $error("Interrupt later than two clocks");
   debug_freeze_a: assert property (
      freeze && !start |=> $stable(count_ff))
      else $error("Counter moved in debug halt");
   upd_flag_a: assert property (
      take |=> upd_ff)
      else $error("Update flag not set");
   upd_clear_a: assert property (
      wr && paddr_i == wdc_pkg::ADDR_RELOAD |=> !upd_ff)
      else $error("Update flag not cleared by a reload write");
   rst_sticky_a: assert property (
      wdt_reset_o |=> wdt_reset_o)
      else $error("Watchdog reset dropped before system reset");
   rst_cause_a: assert property (
      $rose(wdt_reset_o) |-> $past(uf && ctrl_ff.underflow_reset_enable))
      else $error("Watchdog reset without an enabled underflow");
   irq_cause_a: assert property (
      $rose(status[wdc_pkg::IRQ_UNDERFLOW]) |-> $past(uf && ctrl_ff.underflow_irq_enable))
      else $error("Underflow status without interrupt mode");
   step_down_a: assert property (
      step && !pending_ff && count_ff != 32'h0000_0000
      |=> count_ff == $past(count_ff) - 32'h0000_0001)
      else $error("Counter did not step down by one");
   start_edge_a: assert property (
      start |-> !$past(ctrl_ff.counter_enable))
      else $error("Start load without an enable edge");
   ctrl_write_a: assert property (
      wr && paddr_i == wdc_pkg::ADDR_CTRL
      |=> ctrl_ff.counter_enable == $past(pwdata_i[4])
          && ctrl_ff.underflow_reset_enable == $past(pwdata_i[6]))
      else $error("Control enable bits not written");
   pend_take_a: assert property (
      pending_ff && step && !(wr && paddr_i == wdc_pkg::ADDR_RELOAD)
      |=> !pending_ff && upd_ff)
      else $error("Pending reload not taken on the first tick");
   irq_level_a: assert property (
      irq_o == $past(|(status & ien)))
      else $error("Interrupt level does not follow status");

   // Bus answer shape: one access cycle, errors on read-only words
   ready_pulse_a: assert property (
      pready_o |=> !pready_o)
      else $error("Ready held longer than one cycle");
   err_count_a: assert property (
      setup && pwrite_i && paddr_i == wdc_pkg::ADDR_COUNT |=> pslverr_o && pready_o)
      else $error("Write to the count register not refused");
   err_stat_a: assert property (
      setup && pwrite_i && paddr_i == wdc_pkg::ADDR_STAT |=> pslverr_o && pready_o)
      else $error("Write to the status register not refused");

   uf_irq_c: cover property (uf && ctrl_ff.underflow_irq_enable);
   uf_rst_c: cover property ($rose(wdt_reset_o));
   take_c:   cover property (take);
   frz_c:    cover property (freeze && tick);
   ext_tick_c: cover property (ctrl_ff.clock_source_select && tick);
endmodule

// ---- core/wdc_pkg.sv ----
/*
 Shared constants and types of the watchdog down counter: register
 offsets, reset values, control layout, prescaler decode, timing limits.
 Assumes a 32-bit APB register bus decoded on byte offsets.
*/
package wdc_pkg;

   // Byte offsets on the register bus
   localparam logic [7:0] ADDR_RELOAD = 8'h00;
   localparam logic [7:0] ADDR_COUNT  = 8'h04;
   localparam logic [7:0] ADDR_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_STAT   = 8'h0C;
   localparam logic [7:0] ADDR_CLR    = 8'h10;
   localparam logic [7:0] ADDR_IEN    = 8'h14;

   // Values after reset and the control write mask
   localparam logic [31:0] RELOAD_RST   = 32'h0000_0000;
   localparam logic [31:0] COUNT_RST    = 32'h0000_FFFF;
   localparam logic [15:0] CTRL_RST     = 16'h805C;
   localparam logic [15:0] CTRL_WR_MASK = 16'h80DF;

   // Interrupt status layout
   localparam int          IRQ_NUM       = 2;
   localparam int          IRQ_UNDERFLOW = 0;
   localparam int          IRQ_LOADED    = 1;
   localparam logic [1:0]  IEN_RST       = 2'h1;

   // Latency limits in counter clocks and bus clocks
   localparam int LOAD_MAX_TICKS = 5;
   localparam int LAG_MAX_CYC    = 2;

   typedef struct packed {
      logic       debug_halt_control;
      logic [5:0] rsvd_hi;
      logic       load_update_flag;
      logic       underflow_irq_enable;
      logic       underflow_reset_enable;
      logic       rsvd_five;
      logic       counter_enable;
      logic       clock_source_select;
      logic [2:0] prescale_select;
   } wdc_ctrl_t;

   // Last divider state per prescale code: /1, /4, /8 ... /256
   function automatic logic [7:0] prescale_limit(input logic [2:0] code);
      logic [7:0] lim;
      lim = 8'h00;
      unique case (code)
         3'h0: lim = 8'h00;
         3'h1: lim = 8'h03;
         3'h2: lim = 8'h07;
         3'h3: lim = 8'h0F;
         3'h4: lim = 8'h1F;
         3'h5: lim = 8'h3F;
         3'h6: lim = 8'h7F;
         3'h7: lim = 8'hFF;
      endcase
      return lim;
   endfunction

endpackage

// ---- core/wdc_prescaler.sv ----
/*
 Counter clock generator: picks the bus clock or the synchronised
 external clock and divides it to a one-cycle count tick.
 Assumes ext_clk_i is asynchronous and slower than half of clock_i.
*/
module wdc_prescaler (
   input  wire logic       clock_i,
   input  wire logic       rst_b_i,
   input  wire logic       ext_clk_i,
   input  wire logic       run_i,
   input  wire logic       src_sel_i,
   input  wire logic [2:0] code_i,
   output logic            tick_o
);
   logic       sync1_ff;
   logic       sync2_ff;
   logic       prev_ff;
   logic [7:0] div_ff;
   logic       tick_ff;
   logic       base;
   logic       wrap;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         sync1_ff <= ext_clk_i;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign base = src_sel_i ? (sync2_ff & ~prev_ff) : 1'b1;
   // Compare with >= so a code change mid-period cannot overrun
   assign wrap = div_ff >= wdc_pkg::prescale_limit(code_i);

   always_ff @(posedge clock_i) begin
      if (!rst_b_i || !run_i) begin
         div_ff <= 8'h00;
      end else if (base) begin
         div_ff <= wrap ? 8'h00 : div_ff + 8'h01;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= run_i & base & wrap;
      end
   end

   assign tick_o = tick_ff;

   div_one_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      run_i && !src_sel_i && code_i == 3'h0 |=> tick_o)
      else $error("Divide by one did not tick every cycle");
   ext_gate_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      src_sel_i && !(sync2_ff && !prev_ff) |=> !tick_o)
      else $error("Tick without an external clock edge");
endmodule

// ---- core/wdc_irq.sv ----
/*
 Sticky interrupt status with write-one-to-clear, an enable register of
 the same layout and one registered level interrupt.
 Assumes set and write strobes are one-cycle pulses on clock_i.
*/
module wdc_irq #(
   parameter int N = 2
) (
   input  wire logic         clock_i,
   input  wire logic         rst_b_i,
   input  wire logic [N-1:0] set_i,
   input  wire logic         clr_wr_i,
   input  wire logic         ien_wr_i,
   input  wire logic [N-1:0] wdata_i,
   output logic [N-1:0]      status_o,
   output logic [N-1:0]      ien_o,
   output logic              irq_o
);
   logic [N-1:0] status_ff;
   logic [N-1:0] ien_ff;
   logic         irq_ff;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         status_ff <= '0;
      end else begin
         status_ff <= (status_ff & ~(clr_wr_i ? wdata_i : '0)) | set_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         ien_ff <= N'(wdc_pkg::IEN_RST);
      end else if (ien_wr_i) begin
         ien_ff <= wdata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_ff & ien_ff);
      end
   end

   assign status_o = status_ff;
   assign ien_o    = ien_ff;
   assign irq_o    = irq_ff;
endmodule

// ---- tb/tb_wdc_top.sv ----
/*
 Self-checking bench of the watchdog down counter: APB tasks, directed tests.
 Assumes the package and design modules are compiled first; one clock.
*/
module tb_wdc_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock_i;
   logic        rst_b_i;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        ext_clk;
   logic        debug_halt;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        wdt_reset;
   int          failures;
   int          comparisons;

   wdc_top u_dut (
      .clock_i      (clock_i),
      .rst_b_i      (rst_b_i),
      .psel_i       (psel),
      .penable_i    (penable),
      .pwrite_i     (pwrite),
      .paddr_i      (paddr),
      .pwdata_i     (pwdata),
      .ext_clk_i    (ext_clk),
      .debug_halt_i (debug_halt),
      .prdata_o     (prdata),
      .pready_o     (pready),
      .pslverr_o    (pslverr),
      .irq_o        (irq),
      .wdt_reset_o  (wdt_reset)
   );

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic in_range(input int v, input int lo, input int hi);
      check({31'h0, (v >= lo && v <= hi)}, 32'h0000_0001);
   endtask

   // Idle cycle after each transfer keeps one assignment per signal per step
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // Only the bench watchdog ends a wait for ready
      do begin
         @(posedge clock_i);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      bus(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      bus(1'b0, a, 32'h0000_0000, q, e);
   endtask

   task automatic wait_out(input bit rst_sel, output int n);
      n = 0;
      while (((rst_sel ? wdt_reset : irq) !== 1'b1) && n < 2000) begin
         @(posedge clock_i);
         n++;
      end
   endtask

   task automatic do_reset;
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
   endtask

   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #300us;
      failures++;
      conclude();
   end

   initial begin
      logic [31:0] q;
      logic [31:0] q2;
      logic        e;
      int          n;
      int          dv;
      failures = 0;
      comparisons = 0;
      rst_b_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      ext_clk = 1'b0;
      debug_halt = 1'b0;
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      // Ext source idles, so the reset count must not move
      rd(wdc_pkg::ADDR_RELOAD, q); check(q, wdc_pkg::RELOAD_RST);
      rd(wdc_pkg::ADDR_COUNT, q); check(q, wdc_pkg::COUNT_RST);
      rd(wdc_pkg::ADDR_CTRL, q); check(q, {16'h0000, wdc_pkg::CTRL_RST});
      rd(wdc_pkg::ADDR_IEN, q); check(q, 32'h0000_0001);
      rd(wdc_pkg::ADDR_STAT, q); check(q, 32'h0000_0000);
      bus(1'b1, wdc_pkg::ADDR_COUNT, 32'h0000_1234, q, e); check({31'h0, e}, 32'h1);
      bus(1'b0, 8'h20, 32'h0, q, e); check({31'h0, e}, 32'h1);
      check(q, 32'h0000_0000);
      $display("test reset_values done");

      // Reset mode: reload taken while enabled, then time-out
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_8050);
      wr(wdc_pkg::ADDR_RELOAD, 32'h0000_0014);
      rd(wdc_pkg::ADDR_CTRL, q); check(q, 32'h0000_8150);
      rd(wdc_pkg::ADDR_COUNT, q); in_range(int'(q), 8, 20);
      // Kick before zero; without it the reset would be up by now
      wr(wdc_pkg::ADDR_RELOAD, 32'h0000_0014);
      repeat (15) @(posedge clock_i);
      check({31'h0, wdt_reset}, 32'h0);
      wait_out(1'b1, n); in_range(n, 1, 20);
      check({31'h0, irq}, 32'h0);
      rd(wdc_pkg::ADDR_COUNT, q); check(q, 32'h0000_0000);
      $display("test reset_mode done");

      // Interrupt mode: auto reload, clear, mask
      do_reset();
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_8090);
      wr(wdc_pkg::ADDR_RELOAD, 32'h0000_00C8);
      wait_out(1'b0, n); in_range(n, 150, 205);
      check({31'h0, wdt_reset}, 32'h0);
      rd(wdc_pkg::ADDR_STAT, q); check(q, 32'h0000_0003);
      rd(wdc_pkg::ADDR_COUNT, q); in_range(int'(q), 150, 200);
      wr(wdc_pkg::ADDR_CLR, 32'h0000_0003);
      rd(wdc_pkg::ADDR_STAT, q); check(q, 32'h0000_0000);
      check({31'h0, irq}, 32'h0);
      wait_out(1'b0, n); in_range(n, 150, 205);
      wr(wdc_pkg::ADDR_IEN, 32'h0000_0000);
      @(posedge clock_i);
      check({31'h0, irq}, 32'h0);
      wr(wdc_pkg::ADDR_IEN, 32'h0000_0001);
      wr(wdc_pkg::ADDR_CLR, 32'h0000_0001);
      $display("test irq_mode done");

      // Disabled counter holds, enabling loads the reload value
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_8080);
      rd(wdc_pkg::ADDR_COUNT, q);
      rd(wdc_pkg::ADDR_COUNT, q2); check(q2, q);
      wr(wdc_pkg::ADDR_RELOAD, 32'h0000_0064);
      rd(wdc_pkg::ADDR_COUNT, q2); check(q2, q);
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_8090);
      rd(wdc_pkg::ADDR_COUNT, q); in_range(int'(q), 90, 100);
      $display("test enable_load done");

      // Freeze in debug halt when bit 15 is clear
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_0090);
      debug_halt <= 1'b1;
      @(posedge clock_i);
      rd(wdc_pkg::ADDR_COUNT, q);
      rd(wdc_pkg::ADDR_COUNT, q2); check(q2, q);
      debug_halt <= 1'b0;
      // Registered tick needs one more edge before the count moves
      repeat (2) @(posedge clock_i);
      rd(wdc_pkg::ADDR_COUNT, q2); in_range(int'(q2), 1, int'(q) - 1);
      $display("test debug_freeze done");

      // External source: only its rising edges count
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_8088);
      wr(wdc_pkg::ADDR_RELOAD, 32'h0000_0032);
      wr(wdc_pkg::ADDR_CTRL, 32'h0000_8098);
      repeat (6) @(posedge clock_i);
      rd(wdc_pkg::ADDR_COUNT, q); check(q, 32'h0000_0032);
      for (int i = 0; i < 10; i++) begin
         ext_clk <= 1'b1;
         repeat (4) @(posedge clock_i);
         ext_clk <= 1'b0;
         repeat (4) @(posedge clock_i);
      end
      repeat (6) @(posedge clock_i);
      rd(wdc_pkg::ADDR_COUNT, q); check(q, 32'h0000_0028);
      $display("test ext_clock done");

      // Every prescale code, time-out of three counts
      for (int c = 0; c < 8; c++) begin
         dv = (c == 0) ? 1 : (2 << c);
         wr(wdc_pkg::ADDR_CTRL, 32'h0000_8080);
         wr(wdc_pkg::ADDR_CLR, 32'h0000_0003);
         wr(wdc_pkg::ADDR_RELOAD, 32'h0000_0003);
         wr(wdc_pkg::ADDR_CTRL, 32'h0000_8090 | c);
         wait_out(1'b0, n); in_range(n, 2 * dv - 1, 3 * dv + dv + 6);
      end
      $display("test prescale done");
      conclude();
   end
endmodule
